// ---- ppg_warmup_pkg.sv ----
// Constants and types for the cascaded pulse generator and warm-up timer
`default_nettype none
package ppg_warmup_pkg;
  // Write port register selects
  localparam logic [2:0] SEL_LOW_CTRL  = 3'h0;
  localparam logic [2:0] SEL_HIGH_CTRL = 3'h1;
  localparam logic [2:0] SEL_PW_LOW    = 3'h2;
  localparam logic [2:0] SEL_PW_HIGH   = 3'h3;
  localparam logic [2:0] SEL_PER_LOW   = 3'h4;
  localparam logic [2:0] SEL_PER_HIGH  = 3'h5;
  // high_ctrl_reg fields
  localparam int         RUN_BIT       = 3;
  localparam int         TFF_BIT       = 7;
  localparam int         MODE_MSB      = 2;
  localparam logic [2:0] MODE_PPG      = 3'h7;
  localparam logic [2:0] MODE_WARM     = 3'h2;
  // low_ctrl_reg fields
  localparam int         CLK_LSB       = 4;
  localparam int         CLK_MSB       = 6;
  localparam int         CASC_MSB      = 1;
  localparam logic [1:0] CASC_16BIT    = 2'h3;
  // Source clock codes
  localparam logic [2:0] CLK_FC_DIV11  = 3'h0;
  localparam logic [2:0] CLK_FC_DIV7   = 3'h1;
  localparam logic [2:0] CLK_FC_DIV5   = 3'h2;
  localparam logic [2:0] CLK_FC_DIV3   = 3'h3;
  localparam logic [2:0] CLK_FS        = 3'h4;
  localparam logic [2:0] CLK_FC_DIV1   = 3'h5;
  localparam logic [2:0] CLK_FC        = 3'h6;
  localparam logic [2:0] CLK_EXT       = 3'h7;
  // Prescaler
  localparam int         DIV_W         = 11;
  localparam logic [10:0] MASK_DIV11   = 11'h7FF;
  localparam logic [10:0] MASK_DIV7    = 11'h07F;
  localparam logic [10:0] MASK_DIV5    = 11'h01F;
  localparam logic [10:0] MASK_DIV3    = 11'h007;
  localparam logic [10:0] MASK_DIV1    = 11'h001;
  // Reset values
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [15:0] WORD_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_ONE    = 16'h0001;
  // Warm-up compare range: only the upper byte matters
  localparam logic [15:0] WARM_MIN_SET = 16'h0100;
  localparam logic [15:0] WARM_MAX_SET = 16'hFF00;
  // Byte write from the processor side
  typedef struct packed {
    logic       en;
    logic [2:0] sel;
    logic [7:0] data;
  } wr_t;
endpackage
`default_nettype wire

// ---- ppg_warmup_timer.sv ----
// Cascaded 16-bit pulse generator and warm-up counter
// Functional notes
// - PPG mode counts up; width match inverts toggle flop, count continues
// - PPG period match inverts flop again, clears counter, raises match interrupt
// - Toggle flop preloadable from init bit; cleared to zero at reset
// - Pulse pin is inverse of toggle flop
// - Compare values act immediately; software leaves them alone while running
// - Stopping holds pin level; init bit write only after stop
// - High control bit 3 runs counter, bit 7 is init bit
// - Codes 33H, 057H, 05FH select fc/8, PPG mode, start
// - Warm-up mode compares only upper period byte
// - Warm-up mode counts when run, match clears and interrupts
// - Slow warm-up 0100H gives 7.81 ms, FF00H gives 1.99 s
// - Fast warm-up 0100H gives 16 us, FF00H gives 4.08 ms
`default_nettype none
module ppg_warmup_timer
  import ppg_warmup_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire wr_t         i_wr,
  input  wire logic        i_timer_count_pin,
  input  wire logic        i_low_osc_clk,
  output var  logic        o_pulse_out_pin,
  output var  logic        o_count_match_irq,
  output var  logic        o_running,
  output var  logic [15:0] o_count
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisers and edge detect
logic [1:0] sync1;
logic [1:0] sync2;
logic [1:0] sync3;
logic [1:0] fall_edge;

always_ff @(posedge i_clk)
begin
  if (!i_rstn)
  begin
    sync1 <= 2'h0;
    sync2 <= 2'h0;
    sync3 <= 2'h0;
  end
  else
  begin
    sync1 <= {i_low_osc_clk, i_timer_count_pin};
    sync2 <= sync1;
    sync3 <= sync2;
  end
end

assign fall_edge = sync3 & ~sync2;

////////////////////////////////////////////////////////////////////////
// Prescaler
logic [DIV_W-1:0] div;
logic [DIV_W-1:0] next_div;

always_comb
begin
  next_div = div + 11'h001;
end

always_ff @(posedge i_clk)
begin
  if (!i_rstn)
    div <= 11'h000;
  else
    div <= next_div;
end

////////////////////////////////////////////////////////////////////////
// Registers and counter state
logic [7:0]  low_ctrl;
logic [7:0]  high_ctrl;
logic [7:0]  pw_stage;
logic [7:0]  per_stage;
logic [15:0] pw;
logic [15:0] per;
logic [15:0] cnt;
logic        tff;
logic        pin;
logic        irq;
logic [7:0]  next_low_ctrl;
logic [7:0]  next_high_ctrl;
logic [7:0]  next_pw_stage;
logic [7:0]  next_per_stage;
logic [15:0] next_pw;
logic [15:0] next_per;
logic [15:0] next_cnt;
logic        next_tff;
logic        next_irq;
logic        tick;
logic        run;
logic        ppg_mode;
logic        warm_mode;
logic        counting;
logic        per_hit;
logic        pw_hit;
logic        wr_high_ctrl;

assign run          = high_ctrl[RUN_BIT];
assign wr_high_ctrl = i_wr.en && (i_wr.sel == SEL_HIGH_CTRL);

assign ppg_mode  = (high_ctrl[MODE_MSB:0] == MODE_PPG) && (low_ctrl[CASC_MSB:0] == CASC_16BIT);
assign warm_mode = (high_ctrl[MODE_MSB:0] == MODE_WARM) && (low_ctrl[CASC_MSB:0] == CASC_16BIT);
assign counting  = run && (ppg_mode || warm_mode);
assign per_hit   = warm_mode ? (cnt[15:8] == per[15:8]) : (cnt == per);
assign pw_hit    = (cnt == pw);

// source select, fs for slow warm-up
always_comb
begin
  case (low_ctrl[CLK_MSB:CLK_LSB])
    CLK_FC_DIV11: tick = (div & MASK_DIV11) == MASK_DIV11;
    CLK_FC_DIV7:  tick = (div & MASK_DIV7) == MASK_DIV7;
    CLK_FC_DIV5:  tick = (div & MASK_DIV5) == MASK_DIV5;
    CLK_FC_DIV3:  tick = (div & MASK_DIV3) == MASK_DIV3;
    CLK_FS:       tick = fall_edge[1];
    CLK_FC_DIV1:  tick = (div & MASK_DIV1) == MASK_DIV1;
    CLK_FC:       tick = 1'b1;
    CLK_EXT:      tick = fall_edge[0];
    default:      tick = 1'b0;
  endcase
end

always_comb
begin
  next_low_ctrl  = low_ctrl;
  next_high_ctrl = high_ctrl;
  next_pw_stage  = pw_stage;
  next_per_stage = per_stage;
  next_pw        = pw;
  next_per       = per;
  next_cnt       = cnt;
  next_tff       = tff;
  next_irq       = 1'b0;
  if (i_wr.en)
  begin
    case (i_wr.sel)
      SEL_LOW_CTRL:  next_low_ctrl = i_wr.data;
      SEL_HIGH_CTRL: next_high_ctrl = i_wr.data;
      SEL_PW_LOW:    next_pw_stage = i_wr.data;
      SEL_PER_LOW:   next_per_stage = i_wr.data;
      SEL_PW_HIGH:   next_pw = {i_wr.data, pw_stage};
      SEL_PER_HIGH:  next_per = {i_wr.data, per_stage};
      default:       next_low_ctrl = low_ctrl;
    endcase
  end
  if (wr_high_ctrl && !run)
    next_tff = i_wr.data[TFF_BIT];
  if (!counting)
    next_cnt = WORD_RESET;
  else if (tick)
  begin
    if (per_hit)
    begin
      next_cnt = WORD_RESET;
      next_irq = 1'b1;
      if (ppg_mode)
        next_tff = !tff;
    end
    else
    begin
      next_cnt = cnt + COUNT_ONE;
      if (ppg_mode && pw_hit)
        next_tff = !tff;
    end
  end
end

always_ff @(posedge i_clk)
begin
  if (!i_rstn)
  begin
    low_ctrl  <= BYTE_RESET;
    high_ctrl <= BYTE_RESET;
    pw_stage  <= BYTE_RESET;
    per_stage <= BYTE_RESET;
    pw        <= WORD_RESET;
    per       <= WORD_RESET;
    cnt       <= WORD_RESET;
    tff       <= 1'b0;
    pin       <= 1'b1;
    irq       <= 1'b0;
  end
  else
  begin
    low_ctrl  <= next_low_ctrl;
    high_ctrl <= next_high_ctrl;
    pw_stage  <= next_pw_stage;
    per_stage <= next_per_stage;
    pw        <= next_pw;
    per       <= next_per;
    cnt       <= next_cnt;
    tff       <= next_tff;
    pin       <= !next_tff;
    irq       <= next_irq;
  end
end

assign o_pulse_out_pin   = pin;
assign o_count_match_irq = irq;
assign o_running         = high_ctrl[RUN_BIT];
assign o_count           = cnt;

////////////////////////////////////////////////////////////////////////
// Assertions
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_rstn);

sequence seq_period_hit;
  counting && tick && per_hit;
endsequence

sequence seq_cleared;
  (cnt == WORD_RESET) && irq;
endsequence

a_pin_inverse: assert property (o_pulse_out_pin == !tff)
  else $error("pulse pin not inverse of toggle flop");

a_period_clear: assert property (ppg_mode and seq_period_hit |=> seq_cleared ##0 (tff != $past(tff)))
  else $error("period match did not clear, toggle and interrupt");

a_width_toggle: assert property (ppg_mode && counting && tick && pw_hit && !per_hit
  |=> (tff != $past(tff)) && (cnt == $past(cnt) + COUNT_ONE) && !irq)
  else $error("width match did not toggle while counting on");

a_warm_match: assert property (warm_mode and seq_period_hit |=> seq_cleared ##0 $stable(tff))
  else $error("warm-up match did not clear and interrupt");

a_warm_upper: assert property (warm_mode && counting && tick && (cnt[15:8] == per[15:8])
  |=> irq)
  else $error("warm-up compare looked at low byte");

a_hold_stopped: assert property (!run && !wr_high_ctrl
  |=> $stable(tff) ##1 ($stable(tff) || $past(wr_high_ctrl)))
  else $error("toggle flop moved while stopped");

a_stop_keeps: assert property (run && wr_high_ctrl
  |=> tff == ($past(tff) ^ $past(ppg_mode && tick && (per_hit || pw_hit))))
  else $error("init bit loaded in the stopping write");

a_stop_clears: assert property (!run |=> cnt == WORD_RESET)
  else $error("counter moved while stopped");

a_irq_cause: assert property (irq |-> $past(counting && tick && per_hit))
  else $error("interrupt without a period match");

a_reset_clear: assert property (disable iff (1'b0) !i_rstn |=> !tff && o_pulse_out_pin)
  else $error("toggle flop not zero after reset");

// low byte alone has no effect
a_low_no_effect: assert property (i_wr.en && (i_wr.sel == SEL_PER_LOW) |=> $stable(per))
  else $error("period changed on low byte write");

a_high_loads: assert property (i_wr.en && (i_wr.sel == SEL_PW_HIGH)
  |=> pw == {$past(i_wr.data), $past(pw_stage)})
  else $error("width word not loaded on high byte");

a_per_loads: assert property (i_wr.en && (i_wr.sel == SEL_PER_HIGH)
  |=> per == {$past(i_wr.data), $past(per_stage)})
  else $error("period word not loaded on high byte");

a_run_bit: assert property (wr_high_ctrl |=> o_running == $past(i_wr.data[RUN_BIT]))
  else $error("run bit did not follow write");

a_mode_codes: assert property ((low_ctrl == 8'h33) && (high_ctrl == 8'h5F)
  |-> ppg_mode && counting && (low_ctrl[CLK_MSB:CLK_LSB] == CLK_FC_DIV3))
  else $error("mode codes not decoded");

endmodule
`default_nettype wire

// ---- ppg_ext_source.sv ----
// Far-side model: external count clock and slow oscillator
`default_nettype none
module ppg_ext_source (
  input  wire logic i_clk,
  input  wire logic i_ext_en,
  output var  logic o_timer_count_pin,
  output var  logic o_low_osc_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ext_div;
  logic [1:0] osc_div;

  initial
  begin
    ext_div           = 2'h0;
    osc_div           = 2'h0;
    o_timer_count_pin = 1'b1;
    o_low_osc_clk     = 1'b1;
  end

  ////////////////////////////////////////////////////////////////
  // each level held four clocks
  always @(posedge i_clk)
  begin
    if (i_ext_en)
    begin
      ext_div <= ext_div + 2'h1;
      if (ext_div == 2'h3)
        o_timer_count_pin <= ~o_timer_count_pin;
    end
    else
    begin
      ext_div           <= 2'h0;
      o_timer_count_pin <= 1'b1;
    end
    osc_div <= osc_div + 2'h1;
    if (osc_div == 2'h3)
      o_low_osc_clk <= ~o_low_osc_clk;
  end
endmodule
`default_nettype wire

// ---- cascaded_pulse_gen_warmup_timer_test.sv ----
// Self-checking bench for the pulse generator and warm-up timer
`default_nettype none
module cascaded_pulse_gen_warmup_timer_test;
  import ppg_warmup_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk;
  logic        i_rstn;
  wr_t         i_wr;
  logic        ext_en;
  logic        ext_pin;
  logic        osc_clk;
  logic        o_pulse_out_pin;
  logic        o_count_match_irq;
  logic        o_running;
  logic [15:0] o_count;
  int          n_mismatch;
  int          n_compared;

  ppg_warmup_timer u_ppg_warmup_timer (
    .i_clk             (i_clk),
    .i_rstn            (i_rstn),
    .i_wr              (i_wr),
    .i_timer_count_pin (ext_pin),
    .i_low_osc_clk     (osc_clk),
    .o_pulse_out_pin   (o_pulse_out_pin),
    .o_count_match_irq (o_count_match_irq),
    .o_running         (o_running),
    .o_count           (o_count)
  );

  ppg_ext_source u_ppg_ext_source (
    .i_clk             (i_clk),
    .i_ext_en          (ext_en),
    .o_timer_count_pin (ext_pin),
    .o_low_osc_clk     (osc_clk)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= '{en: 1'b1, sel: s, data: d};
    @(posedge i_clk);
    i_wr <= '0;
  endtask

  task automatic setw(input logic [15:0] pw, input logic [15:0] per);
    wr(SEL_PW_LOW, pw[7:0]);
    wr(SEL_PW_HIGH, pw[15:8]);
    wr(SEL_PER_LOW, per[7:0]);
    wr(SEL_PER_HIGH, per[15:8]);
  endtask

  task automatic cyc();
    @(posedge i_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic ppg_walk();
    logic [15:0] c;
    setw(16'h0001, 16'h0003);
    wr(SEL_PER_LOW, 8'h01);
    wr(SEL_LOW_CTRL, 8'h63);
    wr(SEL_HIGH_CTRL, 8'h5F);
    for (int k = 1; k < 10; k++)
    begin
      cyc();
      c = 16'(k % 4);
      check("count", o_count, c);
      check("pin", 16'(o_pulse_out_pin), 16'(c < 2));
      check("irq", 16'(o_count_match_irq), 16'(k > 1 && c == 0));
    end
    $display("ppg_walk done");
  endtask

  task automatic stop_hold();
    for (int k = 0; k < 8 && o_count !== 16'h0003; k++)
      cyc();
    check("stop count", o_count, 16'h0003);
    wr(SEL_HIGH_CTRL, 8'hD7);
    repeat (5)
    begin
      cyc();
      check("held pin", 16'(o_pulse_out_pin), 16'h0001);
      check("run", 16'(o_running), 16'h0000);
    end
    wr(SEL_HIGH_CTRL, 8'hD7);
    cyc();
    check("preload pin", 16'(o_pulse_out_pin), 16'h0000);
    wr(SEL_HIGH_CTRL, 8'h57);
    cyc();
    check("cleared pin", 16'(o_pulse_out_pin), 16'h0001);
    $display("stop_hold done");
  endtask

  task automatic div8();
    logic [15:0] p;
    int          n;
    wr(SEL_LOW_CTRL, 8'h33);
    wr(SEL_HIGH_CTRL, 8'h5F);
    p = o_count;
    for (int k = 0; k < 40 && o_count === p; k++)
      cyc();
    p = o_count;
    for (n = 0; n < 40 && o_count === p; n++)
      cyc();
    check("tick gap", 16'(n), 16'h0008);
    wr(SEL_HIGH_CTRL, 8'h57);
    $display("div8 done");
  endtask

  task automatic ext_count();
    int f;
    f = 0;
    setw(16'h0001, 16'h00FF);
    wr(SEL_LOW_CTRL, 8'h73);
    wr(SEL_HIGH_CTRL, 8'h5F);
    ext_en <= 1'b1;
    repeat (80)
    begin
      @(posedge i_clk);
      if (ext_pin === 1'b1)
        #1 f += int'(ext_pin === 1'b0);
      else
        #1;
    end
    ext_en <= 1'b0;
    repeat (10) cyc();
    check("ext count", o_count, 16'(f));
    wr(SEL_HIGH_CTRL, 8'h57);
    $display("ext_count done");
  endtask

  task automatic warm(input logic [7:0] lc, input logic [15:0] per);
    logic [15:0] p;
    wr(SEL_HIGH_CTRL, 8'h02);
    setw(16'h0001, per);
    wr(SEL_LOW_CTRL, lc);
    wr(SEL_HIGH_CTRL, 8'h0A);
    p = 16'h0000;
    for (int k = 0; k < 4000 && o_count_match_irq !== 1'b1; k++)
    begin
      p = o_count;
      cyc();
    end
    check("warm irq", 16'(o_count_match_irq), 16'h0001);
    check("warm match", p, 16'h0100);
    check("warm pin", 16'(o_pulse_out_pin), 16'h0001);
    wr(SEL_HIGH_CTRL, 8'h02);
    cyc();
    check("warm stop", 16'(o_running), 16'h0000);
    check("warm clear", o_count, 16'h0000);
    $display("warm done");
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    n_mismatch = 0;
    n_compared = 0;
    i_rstn     = 1'b0;
    i_wr       = '0;
    ext_en     = 1'b0;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    #1;
    check("reset pin", 16'(o_pulse_out_pin), 16'h0001);
    check("reset count", o_count, 16'h0000);
    ppg_walk();
    stop_hold();
    div8();
    ext_count();
    warm(8'h63, 16'h01FF);
    warm(8'h43, 16'h0100);
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
